// *** uefa_cfg.svh ***
// Constants for the USB endpoint FIFO access block
`ifndef UEFA_CFG_SVH
`define UEFA_CFG_SVH
`define UEFA_NUM_EP 7
`define UEFA_ADDR_W 10
`define UEFA_EP_SEL_W 3
`define UEFA_FIFO_DEPTH 64
`define UEFA_BYTE_W 8
`define UEFA_COUNT_W 11
`define UEFA_SRC_W 5
`define UEFA_IDX_EP_SELECT 8'hc7
`define UEFA_IDX_FIFO_DATA 8'hcf
`define UEFA_IDX_FIFO_RESET 8'hd5
`define UEFA_IDX_COUNT_LOW 8'he2
`define UEFA_IDX_COUNT_HIGH 8'he3
`define UEFA_IDX_EVT_STATUS 8'hf0
`define UEFA_IDX_EVT_MASK 8'hf1
`define UEFA_IDX_IRQ_SUMMARY 8'hf8
`define UEFA_RST_EP_SELECT 3'h0
`define UEFA_RST_FIFO_RESET 7'h00
`define UEFA_RST_EVT 7'h00
`define UEFA_COUNT_HIGH_LSB 8
`endif

// *** uefa_pkg.sv ***
// Types for the USB endpoint FIFO access block
package uefa_pkg;
	typedef enum logic {UEFA_PH_IDLE, UEFA_PH_ANSWER} uefa_apb_e;
	typedef logic [7:0] uefa_byte_t;
endpackage

// *** uefa_ep_fifo.sv ***
// One endpoint FIFO held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module uefa_ep_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] head,
	output logic empty,
	output logic full
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic do_push;
	logic do_pop;

	assign do_push = push & ~full & ~clear;
	assign do_pop = pop & ~empty & ~clear;
	assign head = mem[rd_ptr];
	assign empty = (count == '0);
	assign full = (count == (AW+1)'(DEPTH));

	// Pointers step one byte per push when not full or pop when not empty, back to start while cleared
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (clear) begin // [R7] [R11]
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_push) wr_ptr <= wr_ptr + 1'b1; // [R11]
			if (do_pop) rd_ptr <= rd_ptr + 1'b1; // [R11]
			count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < DEPTH; k++) mem[k] <= '0;
		end else if (do_push) begin
			mem[wr_ptr] <= push_data;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_clear_empties: assert property (clear |=> empty && rd_ptr == '0 && wr_ptr == '0) // [R7]
		else $error("fifo not emptied by clear");
	chk_push_steps: assert property ((push && !pop && !full && !clear) |=> count == $past(count) + 1'b1) // [R11]
		else $error("push did not advance by one");
	chk_pop_steps: assert property ((pop && !push && !empty && !clear) |=> count == $past(count) - 1'b1) // [R11]
		else $error("pop did not advance by one");
endmodule
`default_nettype wire

// *** uefa_rx_count.sv ***
// Byte count of the last received data packet of one endpoint
`timescale 1ns/1ps
`default_nettype none
module uefa_rx_count #(
	parameter int COUNT_W = 11
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic byte_valid,
	input wire logic pkt_end,
	output logic [COUNT_W-1:0] count
);
	logic [COUNT_W-1:0] run;
	logic [COUNT_W-1:0] next_run;

	// Saturating count of data bytes after the packet identifier
	always_comb begin
		next_run = run;
		if (byte_valid && run != '1) next_run = run + 1'b1; // [R4]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run <= '0;
			count <= '0;
		end else if (clear) begin
			run <= '0;
			count <= '0;
		end else if (pkt_end) begin
			run <= '0;
			count <= next_run; // [R4]
		end else begin
			run <= next_run;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_count_latch: assert property ((pkt_end && !clear) |=> count == $past(next_run) && run == '0) // [R4]
		else $error("packet byte count not latched");
endmodule
`default_nettype wire

// *** uefa_top.sv ***
// USB endpoint FIFO access path: APB registers, endpoint FIFOs and interrupt summary
//
// What this block does
// R1 - Data port write pushes, read pops one byte of the selected endpoint FIFO.
// R2 - Low count register shows bits 7..0 of last received packet count.
// R3 - High count register shows count bits 10..8 in bits 2..0.
// R4 - Count holds data bytes after the data identifier, no identifier or CRC.
// R5 - Upper bits of high count register read zero; firmware writes zero.
// R6 - Bit 7 of FIFO reset register reads zero; firmware never sets it.
// R7 - Each reset bit holds its endpoint FIFO cleared while set.
// R8 - Firmware pulses each FIFO reset bit after any reset before using endpoint.
// R9 - Interrupt summary register is read-only, one flag per endpoint, bit 7 unused.
// R10 - Summary flag follows OR of the endpoint's five status sources.
// R11 - Each data port access advances the FIFO pointer one byte; reset rewinds. Code skips writes to a full FIFO and reads of an empty one.
`timescale 1ns/1ps
`default_nettype none
`include "uefa_cfg.svh"
module uefa_top #(
	parameter int FIFO_DEPTH = `UEFA_FIFO_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`UEFA_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sie_rx_valid,
	input wire logic [`UEFA_EP_SEL_W-1:0] sie_rx_ep,
	input wire logic [`UEFA_BYTE_W-1:0] sie_rx_byte,
	input wire logic sie_rx_end,
	input wire logic sie_tx_pop,
	input wire logic [`UEFA_EP_SEL_W-1:0] sie_tx_ep,
	output logic [`UEFA_BYTE_W-1:0] sie_tx_byte,
	input wire logic [`UEFA_NUM_EP*`UEFA_SRC_W-1:0] ep_src_flags,
	output logic [`UEFA_NUM_EP-1:0] fifo_held,
	output logic irq
);
	localparam int NEP = `UEFA_NUM_EP;

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic reg_hit(input logic [`UEFA_ADDR_W-1:0] a, input logic [7:0] idx);
		return a == {idx, 2'b00};
	endfunction

	function automatic logic ep_ok(input logic [`UEFA_EP_SEL_W-1:0] ep);
		return ep < `UEFA_EP_SEL_W'(NEP);
	endfunction

	uefa_pkg::uefa_apb_e state;
	logic [`UEFA_EP_SEL_W-1:0] ep_sel;
	logic [NEP-1:0] fifo_rst;
	logic [NEP-1:0] summary;
	logic [NEP-1:0] evt_status;
	logic [NEP-1:0] evt_mask;
	logic [NEP-1:0] src_or;
	logic [NEP-1:0] cpu_push;
	logic [NEP-1:0] cpu_pop;
	logic [NEP-1:0] fifo_empty;
	logic [NEP-1:0] fifo_full;
	uefa_pkg::uefa_byte_t head [NEP];
	logic [`UEFA_COUNT_W-1:0] bc [NEP];
	uefa_pkg::uefa_byte_t head_sel;
	logic [`UEFA_COUNT_W-1:0] bc_sel;
	logic [31:0] rd_value;
	logic mapped;
	logic setup;
	logic done;
	logic wr_done;
	logic rd_done;
	logic data_hit;

	assign setup = psel & ~penable;
	assign done = psel & penable & pready;
	assign wr_done = done & pwrite;
	assign rd_done = done & ~pwrite;
	assign data_hit = reg_hit(paddr, `UEFA_IDX_FIFO_DATA) & ep_ok(ep_sel);
	assign head_sel = ep_ok(ep_sel) ? head[ep_sel] : '0;
	assign bc_sel = ep_ok(ep_sel) ? bc[ep_sel] : '0;

	////////////////////////////////////////////////////////////////////////////////
	// Endpoint FIFOs, byte counters and summary flags

	for (genvar i = 0; i < NEP; i++) begin : g_ep
		logic sie_push;
		logic sie_pop;
		assign sie_push = sie_rx_valid & (sie_rx_ep == `UEFA_EP_SEL_W'(i));
		assign sie_pop = sie_tx_pop & (sie_tx_ep == `UEFA_EP_SEL_W'(i));
		assign cpu_push[i] = wr_done & data_hit & (ep_sel == `UEFA_EP_SEL_W'(i)); // [R1]
		assign cpu_pop[i] = rd_done & data_hit & (ep_sel == `UEFA_EP_SEL_W'(i)); // [R1]
		assign src_or[i] = |ep_src_flags[i*`UEFA_SRC_W +: `UEFA_SRC_W]; // [R10]

		uefa_ep_fifo #(
			.WIDTH(`UEFA_BYTE_W),
			.DEPTH(FIFO_DEPTH)
		) u_fifo (
			.clk(pclk),
			.rst_n(presetn),
			.clear(fifo_rst[i]), // [R7]
			.push(sie_push | cpu_push[i]),
			.push_data(sie_push ? sie_rx_byte : pwdata[`UEFA_BYTE_W-1:0]),
			.pop(sie_pop | cpu_pop[i]),
			.head(head[i]),
			.empty(fifo_empty[i]),
			.full(fifo_full[i])
		);

		uefa_rx_count #(
			.COUNT_W(`UEFA_COUNT_W)
		) u_count (
			.clk(pclk),
			.rst_n(presetn),
			.clear(fifo_rst[i]),
			.byte_valid(sie_push),
			.pkt_end(sie_rx_end & (sie_rx_ep == `UEFA_EP_SEL_W'(i))),
			.count(bc[i])
		);
	end

	// Summary flags follow their sources and clear with them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) summary <= '0;
		else summary <= src_or; // [R10]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) sie_tx_byte <= '0;
		else if (sie_tx_pop && ep_ok(sie_tx_ep)) sie_tx_byte <= head[sie_tx_ep];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux

	always_comb begin
		rd_value = '0;
		mapped = 1'b1;
		if (reg_hit(paddr, `UEFA_IDX_FIFO_DATA)) begin
			rd_value[`UEFA_BYTE_W-1:0] = head_sel; // [R1]
		end else if (reg_hit(paddr, `UEFA_IDX_EP_SELECT)) begin
			rd_value[`UEFA_EP_SEL_W-1:0] = ep_sel;
		end else if (reg_hit(paddr, `UEFA_IDX_FIFO_RESET)) begin
			rd_value[NEP-1:0] = fifo_rst; // [R6]
		end else if (reg_hit(paddr, `UEFA_IDX_COUNT_LOW)) begin
			rd_value[`UEFA_COUNT_HIGH_LSB-1:0] = bc_sel[`UEFA_COUNT_HIGH_LSB-1:0]; // [R2]
		end else if (reg_hit(paddr, `UEFA_IDX_COUNT_HIGH)) begin
			rd_value[`UEFA_COUNT_W-`UEFA_COUNT_HIGH_LSB-1:0] =
				bc_sel[`UEFA_COUNT_W-1:`UEFA_COUNT_HIGH_LSB]; // [R3] [R5]
		end else if (reg_hit(paddr, `UEFA_IDX_IRQ_SUMMARY)) begin
			rd_value[NEP-1:0] = summary; // [R9]
		end else if (reg_hit(paddr, `UEFA_IDX_EVT_STATUS)) begin
			rd_value[NEP-1:0] = evt_status;
		end else if (reg_hit(paddr, `UEFA_IDX_EVT_MASK)) begin
			rd_value[NEP-1:0] = evt_mask;
		end else begin
			mapped = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB answer: ready one cycle after setup

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= uefa_pkg::UEFA_PH_IDLE;
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			unique case (state)
				uefa_pkg::UEFA_PH_IDLE: begin
					if (setup) begin
						state <= uefa_pkg::UEFA_PH_ANSWER;
						pready <= 1'b1;
						prdata <= pwrite ? 32'h0000_0000 : rd_value;
						pslverr <= ~mapped;
					end
				end
				uefa_pkg::UEFA_PH_ANSWER: begin
					if (done) begin
						state <= uefa_pkg::UEFA_PH_IDLE;
						pready <= 1'b0;
						pslverr <= 1'b0;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software written registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ep_sel <= `UEFA_RST_EP_SELECT;
		else if (wr_done && reg_hit(paddr, `UEFA_IDX_EP_SELECT)) ep_sel <= pwdata[`UEFA_EP_SEL_W-1:0];
	end

	// Bit 7 is not stored, so it can never hold a FIFO or read back set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) fifo_rst <= `UEFA_RST_FIFO_RESET;
		else if (wr_done && reg_hit(paddr, `UEFA_IDX_FIFO_RESET)) fifo_rst <= pwdata[NEP-1:0]; // [R6] [R7]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) fifo_held <= '0;
		else fifo_held <= fifo_rst;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt: rising summary flags are sticky, write one to clear, set wins

	logic [NEP-1:0] evt_set;
	logic [NEP-1:0] evt_clr;
	assign evt_set = src_or & ~summary;
	assign evt_clr = (wr_done && reg_hit(paddr, `UEFA_IDX_EVT_STATUS)) ? pwdata[NEP-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) evt_status <= `UEFA_RST_EVT;
		else evt_status <= (evt_status & ~evt_clr) | evt_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) evt_mask <= `UEFA_RST_EVT;
		else if (wr_done && reg_hit(paddr, `UEFA_IDX_EVT_MASK)) evt_mask <= pwdata[NEP-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) irq <= 1'b0;
		else irq <= |(evt_status & evt_mask);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_data_read_head: assert property ((setup && !pwrite && data_hit) |=> prdata == {24'h0, $past(head_sel)}) // [R1]
		else $error("data port read not the FIFO head");
	chk_data_write_push: assert property ((wr_done && data_hit && !sie_rx_valid && !fifo_full[ep_sel]
		&& !fifo_rst[ep_sel]) |=> !fifo_empty[$past(ep_sel)]) // [R1]
		else $error("data port write did not push");
	chk_count_low: assert property ((setup && !pwrite && reg_hit(paddr, `UEFA_IDX_COUNT_LOW))
		|=> prdata == {24'h0, $past(bc_sel[7:0])}) // [R2]
		else $error("low count read wrong");
	chk_count_high: assert property ((setup && !pwrite && reg_hit(paddr, `UEFA_IDX_COUNT_HIGH))
		|=> prdata[2:0] == $past(bc_sel[10:8])) // [R3]
		else $error("high count read wrong");
	chk_high_upper_zero: assert property ((setup && reg_hit(paddr, `UEFA_IDX_COUNT_HIGH)) |=> prdata[31:3] == '0) // [R5]
		else $error("high count upper bits not zero");
	chk_reset_top_zero: assert property ((setup && reg_hit(paddr, `UEFA_IDX_FIFO_RESET)) |=> prdata[31:7] == '0) // [R6]
		else $error("fifo reset bit 7 not zero");
	chk_reset_holds: assert property (fifo_rst[ep_sel] && ep_ok(ep_sel) |=> ##1 (fifo_empty[$past(ep_sel, 2)]
		|| !fifo_rst[$past(ep_sel, 2)])) // [R7]
		else $error("fifo not held while reset bit set");
	chk_summary_ro: assert property ((wr_done && reg_hit(paddr, `UEFA_IDX_IRQ_SUMMARY)) |=> summary == $past(src_or)) // [R9]
		else $error("summary changed by write");
	chk_summary_follow: assert property (##1 summary == $past(src_or)) // [R10]
		else $error("summary flag does not follow sources");
	chk_answer_timing: assert property (setup |=> pready ##1 !pready)
		else $error("apb answer timing wrong");
	chk_write_reads_zero: assert property ((setup && pwrite) |=> prdata == '0)
		else $error("write answer carried read data");
	chk_unmapped_error: assert property ((setup && !mapped) |=> pslverr && pready)
		else $error("unmapped address gave no error");
	chk_held_copy: assert property (##1 fifo_held == $past(fifo_rst)) // [R7]
		else $error("held flags do not follow reset bits");
	chk_count_cleared: assert property ((fifo_rst[ep_sel] && ep_ok(ep_sel)) |=> bc[$past(ep_sel)] == '0) // [R7]
		else $error("byte count not cleared by fifo reset");
	chk_summary_read: assert property ((setup && !pwrite && reg_hit(paddr, `UEFA_IDX_IRQ_SUMMARY)) // [R9]
		|=> prdata == {25'h0, $past(summary)})
		else $error("summary read wrong or bit 7 set");
	chk_tx_head: assert property ((sie_tx_pop && ep_ok(sie_tx_ep)) |=> sie_tx_byte == $past(head[sie_tx_ep])) // [R1]
		else $error("serial engine did not get the FIFO head");
	chk_status_set_wins: assert property ((evt_set != '0) |=> (evt_status & $past(evt_set)) == $past(evt_set))
		else $error("event lost against a clear");
	chk_irq_raise: assert property ((evt_status & evt_mask) != '0 |=> irq)
		else $error("unmasked event did not raise irq");
	chk_mask_write: assert property ((wr_done && reg_hit(paddr, `UEFA_IDX_EVT_MASK)) |=> evt_mask == $past(pwdata[NEP-1:0]))
		else $error("mask write not stored");

	cov_data_read: cover property (rd_done && data_hit);
	cov_data_write: cover property (wr_done && data_hit);
	cov_irq_rise: cover property (!irq ##1 irq);
	cov_fifo_pulse: cover property (fifo_rst[0] ##1 !fifo_rst[0]);
	cov_rx_packet: cover property (sie_rx_end && ep_ok(sie_rx_ep));
endmodule
`default_nettype wire

// *** uefa_sie_model.sv ***
// Serial interface engine and host model for the endpoint FIFO block
`timescale 1ns/1ps
`default_nettype none
module uefa_sie_model (
	input wire logic pclk,
	output logic sie_rx_valid,
	output logic [2:0] sie_rx_ep,
	output logic [7:0] sie_rx_byte,
	output logic sie_rx_end,
	output logic sie_tx_pop,
	output logic [2:0] sie_tx_ep,
	output logic [34:0] ep_src_flags
);
	initial begin
		sie_rx_valid = 1'b0;
		sie_rx_ep = 3'h0;
		sie_rx_byte = 8'h00;
		sie_rx_end = 1'b0;
		sie_tx_pop = 1'b0;
		sie_tx_ep = 3'h0;
		ep_src_flags = 35'h0;
	end
	////////////////////////////////////////////////////////////////
	// Sends data bytes only, identifier and CRC already stripped
	task automatic send(input logic [2:0] ep, input int n, input logic [7:0] base);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			sie_rx_valid <= 1'b1;
			sie_rx_ep <= ep;
			sie_rx_byte <= base + 8'(i);
			sie_rx_end <= (i == n - 1);
		end
		@(posedge pclk);
		sie_rx_valid <= 1'b0;
		sie_rx_end <= 1'b0;
		sie_rx_byte <= ~sie_rx_byte;
	endtask
	// Takes one byte from an endpoint FIFO
	task automatic pop(input logic [2:0] ep);
		@(posedge pclk);
		sie_tx_pop <= 1'b1;
		sie_tx_ep <= ep;
		@(posedge pclk);
		sie_tx_pop <= 1'b0;
	endtask
	// Sets the endpoint status sources
	task automatic src(input logic [34:0] v);
		@(posedge pclk);
		ep_src_flags <= v;
	endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Testbench for the endpoint FIFO access block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [9:0] paddr = 10'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, sie_rx_valid, sie_rx_end, sie_tx_pop, irq;
	logic [2:0] sie_rx_ep, sie_tx_ep;
	logic [7:0] sie_rx_byte, sie_tx_byte;
	logic [34:0] ep_src_flags;
	logic [6:0] fifo_held;
	int miscompares = 0, samples_checked = 0;
	localparam logic [9:0] SEL = 10'h31c, DAT = 10'h33c, FRST = 10'h354, CLO = 10'h388;
	localparam logic [9:0] CHI = 10'h38c, STA = 10'h3c0, MSK = 10'h3c4, SUM = 10'h3e0;
	always #25 pclk = ~pclk;
	uefa_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sie_rx_valid(sie_rx_valid), .sie_rx_ep(sie_rx_ep), .sie_rx_byte(sie_rx_byte),
		.sie_rx_end(sie_rx_end), .sie_tx_pop(sie_tx_pop), .sie_tx_ep(sie_tx_ep),
		.sie_tx_byte(sie_tx_byte), .ep_src_flags(ep_src_flags), .fifo_held(fifo_held), .irq(irq));
	uefa_sie_model sie (.pclk(pclk), .sie_rx_valid(sie_rx_valid), .sie_rx_ep(sie_rx_ep),
		.sie_rx_byte(sie_rx_byte), .sie_rx_end(sie_rx_end), .sie_tx_pop(sie_tx_pop),
		.sie_tx_ep(sie_tx_ep), .ep_src_flags(ep_src_flags));
	////////////////////////////////////////////////////////////////
	task automatic results();
		$display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			miscompares++;
			$display("BAD pready expected 1 seen timeout");
			results();
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, r);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		tick(10);
		presetn <= 1'b1;
		rd(FRST, 32'h0, "fifo_reset");
		rd(CLO, 32'h0, "count_low");
		rd(CHI, 32'h0, "count_high");
		rd(SUM, 32'h0, "summary");
		apb(1'b0, 10'h004, 32'h0);
		chk("pslverr", 32'h1, {31'h0, e});
		// Firmware pulses every FIFO reset bit before use
		wr(FRST, 32'h7f);
		tick(2);
		chk("fifo_held", 32'h7f, {25'h0, fifo_held});
		wr(FRST, 32'h0);
		rd(FRST, 32'h0, "fifo_reset");
		wr(SEL, 32'h2);
		for (int i = 0; i < 3; i++) wr(DAT, 32'ha0 + i);
		for (int i = 0; i < 3; i++) rd(DAT, 32'ha0 + i, "fifo_byte");
		wr(SEL, 32'h1);
		wr(DAT, 32'h5a);
		wr(DAT, 32'h6b);
		sie.pop(3'h1);
		#1 chk("tx_byte", 32'h5a, {24'h0, sie_tx_byte});
		sie.pop(3'h1);
		#1 chk("tx_byte", 32'h6b, {24'h0, sie_tx_byte});
		sie.send(3'h3, 1030, 8'h10);
		tick(2);
		wr(SEL, 32'h3);
		rd(CLO, 32'h06, "count_low");
		rd(CHI, 32'h04, "count_high");
		rd(DAT, 32'h10, "fifo_byte");
		rd(DAT, 32'h11, "fifo_byte");
		sie.send(3'h3, 1, 8'h00);
		tick(2);
		rd(CLO, 32'h01, "count_low");
		// Held FIFO drops bytes and loses its count
		wr(FRST, 32'h08);
		sie.send(3'h3, 2, 8'h40);
		tick(2);
		chk("fifo_held", 32'h08, {25'h0, fifo_held});
		rd(CLO, 32'h0, "count_low");
		wr(FRST, 32'h0);
		wr(DAT, 32'h77);
		rd(DAT, 32'h77, "fifo_byte");
		wr(MSK, 32'h20);
		for (int s = 0; s < 5; s++) begin
			sie.src(35'h1 << (25 + s));
			tick(4);
			rd(SUM, 32'h20, "summary");
			chk("irq", 32'h1, {31'h0, irq});
			wr(STA, 32'h20);
			sie.src(35'h0);
			tick(4);
			chk("irq", 32'h0, {31'h0, irq});
			rd(SUM, 32'h0, "summary");
		end
		wr(MSK, 32'h0);
		sie.src(35'h1 << 22);
		tick(4);
		chk("irq", 32'h0, {31'h0, irq});
		rd(STA, 32'h10, "evt_status");
		wr(SUM, 32'hff);
		rd(SUM, 32'h10, "summary");
		wr(STA, 32'h10);
		rd(STA, 32'h0, "evt_status");
		results();
	end
endmodule
`default_nettype wire
